// File: rtl/dprp_ref_profile.v
// The APB slave port was decided locally.
`timescale 1ns/1ns
`include "dprp_regs.vh"

module dprp_ref_profile #(
    parameter ADDR_W = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire [1:0] reference_priority_level,
    output wire reference_lock_permit,
    output wire [15:0] loop_bw_scale,
    output wire loop_filter_high_pm,
    output wire [16:0] integer_feedback_divider_m1,
    output wire [17:0] integer_feedback_divider,
    output wire [22:0] fraction_numerator,
    output wire [22:0] fraction_modulus,
    output wire fraction_valid
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------

    // Maps a word index to a bank slot, or to the no-slot code.
    function [3:0] slot_of;
        input [ADDR_W-3:0] idx;
        begin
            case (idx)
                `DPRP_IDX_REF_PRIORITY_ENABLE: slot_of = `DPRP_SLOT_PRIO;
                `DPRP_IDX_LOOP_BW_SCALE_LOW: slot_of = `DPRP_SLOT_BW_LO;
                `DPRP_IDX_LOOP_BW_SCALE_HIGH: slot_of = `DPRP_SLOT_BW_HI;
                `DPRP_IDX_LOOP_FILTER_SELECT: slot_of = `DPRP_SLOT_FILT;
                `DPRP_IDX_INT_DIVIDER_LOW: slot_of = `DPRP_SLOT_INT_LO;
                `DPRP_IDX_INT_DIVIDER_MID: slot_of = `DPRP_SLOT_INT_MID;
                `DPRP_IDX_INT_DIVIDER_TOP: slot_of = `DPRP_SLOT_INT_TOP;
                `DPRP_IDX_FRAC_NUMERATOR_LOW: slot_of = `DPRP_SLOT_NUM_LO;
                `DPRP_IDX_FRAC_NUMERATOR_MID: slot_of = `DPRP_SLOT_NUM_MID;
                `DPRP_IDX_FRAC_NUMERATOR_TOP: slot_of = `DPRP_SLOT_NUM_TOP;
                `DPRP_IDX_FRAC_MODULUS_LOW: slot_of = `DPRP_SLOT_MOD_LO;
                `DPRP_IDX_FRAC_MODULUS_MID: slot_of = `DPRP_SLOT_MOD_MID;
                `DPRP_IDX_FRAC_MODULUS_TOP: slot_of = `DPRP_SLOT_MOD_TOP;
                `DPRP_IDX_PROFILE_STATUS: slot_of = `DPRP_SLOT_STATUS;
                default: slot_of = `DPRP_SLOT_NONE;
            endcase
        end
    endfunction

    // Bits that software may change in each slot; all others stay zero.
    function [7:0] wmask_of;
        input [3:0] slot;
        begin
            case (slot)
                `DPRP_SLOT_PRIO: wmask_of = `DPRP_MASK_PRIO;
                `DPRP_SLOT_BW_LO: wmask_of = `DPRP_MASK_FULL;
                `DPRP_SLOT_BW_HI: wmask_of = `DPRP_MASK_FULL;
                `DPRP_SLOT_FILT: wmask_of = `DPRP_MASK_FILT;
                `DPRP_SLOT_INT_LO: wmask_of = `DPRP_MASK_FULL;
                `DPRP_SLOT_INT_MID: wmask_of = `DPRP_MASK_FULL;
                `DPRP_SLOT_INT_TOP: wmask_of = `DPRP_MASK_INT_TOP;
                `DPRP_SLOT_NUM_LO: wmask_of = `DPRP_MASK_FULL;
                `DPRP_SLOT_NUM_MID: wmask_of = `DPRP_MASK_FULL;
                `DPRP_SLOT_NUM_TOP: wmask_of = `DPRP_MASK_TOP7;
                `DPRP_SLOT_MOD_LO: wmask_of = `DPRP_MASK_FULL;
                `DPRP_SLOT_MOD_MID: wmask_of = `DPRP_MASK_FULL;
                `DPRP_SLOT_MOD_TOP: wmask_of = `DPRP_MASK_TOP7;
                default: wmask_of = `DPRP_MASK_NONE;
            endcase
        end
    endfunction

    // Reset contents of each storage slot.
    function [7:0] rst_of;
        input [3:0] slot;
        begin
            case (slot)
                `DPRP_SLOT_PRIO: rst_of = `DPRP_RST_PRIO;
                `DPRP_SLOT_BW_LO: rst_of = `DPRP_RST_BW_LO;
                `DPRP_SLOT_BW_HI: rst_of = `DPRP_RST_BW_HI;
                `DPRP_SLOT_FILT: rst_of = `DPRP_RST_FILT;
                `DPRP_SLOT_INT_LO: rst_of = `DPRP_RST_INT_LO;
                `DPRP_SLOT_INT_MID: rst_of = `DPRP_RST_INT_MID;
                `DPRP_SLOT_INT_TOP: rst_of = `DPRP_RST_INT_TOP;
                `DPRP_SLOT_NUM_LO: rst_of = `DPRP_RST_NUM_LO;
                `DPRP_SLOT_NUM_MID: rst_of = `DPRP_RST_NUM_MID;
                `DPRP_SLOT_NUM_TOP: rst_of = `DPRP_RST_NUM_TOP;
                `DPRP_SLOT_MOD_LO: rst_of = `DPRP_RST_MOD_LO;
                `DPRP_SLOT_MOD_MID: rst_of = `DPRP_RST_MOD_MID;
                `DPRP_SLOT_MOD_TOP: rst_of = `DPRP_RST_MOD_TOP;
                default: rst_of = 8'h00;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------

    wire setup_phase;
    wire access_phase;
    wire [3:0] req_slot;
    wire word_aligned;
    wire req_mapped;
    wire req_error;
    wire wr_fire;

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign word_aligned = (paddr[1:0] == 2'b00);
    assign req_slot = word_aligned ? slot_of(paddr[ADDR_W-1:2])
                                   : `DPRP_SLOT_NONE;
    assign req_mapped = (req_slot != `DPRP_SLOT_NONE);
    // The status word is read only, so a write to it is refused.
    assign req_error = ~req_mapped |
                       (pwrite & (req_slot == `DPRP_SLOT_STATUS));

    // A write lands only at the access edge; pready is high at every edge, setup included.
    assign wr_fire = access_phase & pwrite & ~req_error & pstrb[0];

    // Zero-wait slave: every access phase completes in one cycle.
    assign pready = 1'b1;
    assign pslverr = access_phase & req_error;

    // ------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------

    reg [7:0] bank_q [0:`DPRP_NUM_SLOTS-2];

    genvar gi;
    generate
        for (gi = 0; gi < `DPRP_NUM_SLOTS - 1; gi = gi + 1)
        begin : g_bank
            localparam [3:0] SLOT_ID = gi;
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    bank_q[gi] <= rst_of(SLOT_ID);
                end
                else if (wr_fire && (req_slot == SLOT_ID))
                begin
                    // Reserved bits stay zero whatever is written.
                    bank_q[gi] <= pwdata[7:0] & wmask_of(SLOT_ID);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Fields seen by the loop
    // ------------------------------------------------------------------

    wire [16:0] div_m1_w;
    wire [22:0] num_w;
    wire [22:0] mod_w;

    assign reference_lock_permit =
        bank_q[`DPRP_SLOT_PRIO][`DPRP_BIT_ENABLE];
    assign reference_priority_level =
        bank_q[`DPRP_SLOT_PRIO][`DPRP_BIT_PRIO_HI:`DPRP_BIT_PRIO_LO];
    assign loop_bw_scale = {bank_q[`DPRP_SLOT_BW_HI],
                            bank_q[`DPRP_SLOT_BW_LO]};
    assign loop_filter_high_pm =
        bank_q[`DPRP_SLOT_FILT][`DPRP_BIT_FILTER_HPM];

    assign div_m1_w = {bank_q[`DPRP_SLOT_INT_TOP][`DPRP_BIT_INT_B16],
                       bank_q[`DPRP_SLOT_INT_MID],
                       bank_q[`DPRP_SLOT_INT_LO]};
    assign num_w = {bank_q[`DPRP_SLOT_NUM_TOP][6:0],
                    bank_q[`DPRP_SLOT_NUM_MID],
                    bank_q[`DPRP_SLOT_NUM_LO]};
    assign mod_w = {bank_q[`DPRP_SLOT_MOD_TOP][6:0],
                    bank_q[`DPRP_SLOT_MOD_MID],
                    bank_q[`DPRP_SLOT_MOD_LO]};

    assign integer_feedback_divider_m1 = div_m1_w;
    assign fraction_numerator = num_w;
    assign fraction_modulus = mod_w;

    // ------------------------------------------------------------------
    // Effective division terms
    // ------------------------------------------------------------------

    // The true divider and the fraction check are registered so that the
    // adder and comparator stay off the loop's timing path; they follow a
    // write one cycle later than the raw fields.
    reg [17:0] div_true_q;
    reg mod_zero_q;
    reg num_over_q;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_true_q <= 18'h007CC;
            mod_zero_q <= 1'b0;
            num_over_q <= 1'b0;
        end
        else
        begin
            div_true_q <= {1'b0, div_m1_w} + 18'h00001;
            mod_zero_q <= (mod_w == 23'h000000);
            num_over_q <= (num_w >= mod_w);
        end
    end

    assign integer_feedback_divider = div_true_q;
    // A fraction is usable only with a nonzero modulus above the numerator.
    assign fraction_valid = ~mod_zero_q & ~num_over_q;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    reg [7:0] rd_byte_d;
    reg [31:0] prdata_q;

    always @*
    begin
        rd_byte_d = 8'h00;
        if (req_slot == `DPRP_SLOT_STATUS)
        begin
            rd_byte_d[`DPRP_BIT_STAT_PERMIT] = reference_lock_permit;
            rd_byte_d[`DPRP_BIT_STAT_MOD_ZERO] = mod_zero_q;
            rd_byte_d[`DPRP_BIT_STAT_NUM_OVER] = num_over_q;
        end
        else if (req_mapped)
        begin
            rd_byte_d = bank_q[req_slot] & wmask_of(req_slot);
        end
    end

    // Read data is caught in the setup cycle and stands through access.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h00000000;
        end
        else if (setup_phase && !pwrite)
        begin
            prdata_q <= {24'h000000, rd_byte_d};
        end
    end

    assign prdata = prdata_q;

endmodule // dprp_ref_profile

// File: rtl/dprp_regs.vh
`ifndef DPRP_REGS_VH
`define DPRP_REGS_VH

// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------
`define DPRP_IDX_REF_PRIORITY_ENABLE 12'h567
`define DPRP_IDX_LOOP_BW_SCALE_LOW 12'h568
`define DPRP_IDX_LOOP_BW_SCALE_HIGH 12'h569
`define DPRP_IDX_LOOP_FILTER_SELECT 12'h56A
`define DPRP_IDX_INT_DIVIDER_LOW 12'h56B
`define DPRP_IDX_INT_DIVIDER_MID 12'h56C
`define DPRP_IDX_INT_DIVIDER_TOP 12'h56D
`define DPRP_IDX_FRAC_NUMERATOR_LOW 12'h56E
`define DPRP_IDX_FRAC_NUMERATOR_MID 12'h56F
`define DPRP_IDX_FRAC_NUMERATOR_TOP 12'h570
`define DPRP_IDX_FRAC_MODULUS_LOW 12'h571
`define DPRP_IDX_FRAC_MODULUS_MID 12'h572
`define DPRP_IDX_FRAC_MODULUS_TOP 12'h573
`define DPRP_IDX_PROFILE_STATUS 12'h574

// ----------------------------------------------------------------------
// Slot numbers inside the bank.
// ----------------------------------------------------------------------
`define DPRP_NUM_SLOTS 14
`define DPRP_SLOT_PRIO 4'h0
`define DPRP_SLOT_BW_LO 4'h1
`define DPRP_SLOT_BW_HI 4'h2
`define DPRP_SLOT_FILT 4'h3
`define DPRP_SLOT_INT_LO 4'h4
`define DPRP_SLOT_INT_MID 4'h5
`define DPRP_SLOT_INT_TOP 4'h6
`define DPRP_SLOT_NUM_LO 4'h7
`define DPRP_SLOT_NUM_MID 4'h8
`define DPRP_SLOT_NUM_TOP 4'h9
`define DPRP_SLOT_MOD_LO 4'hA
`define DPRP_SLOT_MOD_MID 4'hB
`define DPRP_SLOT_MOD_TOP 4'hC
`define DPRP_SLOT_STATUS 4'hD
`define DPRP_SLOT_NONE 4'hF

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define DPRP_RST_PRIO 8'h00
`define DPRP_RST_BW_LO 8'hF4
`define DPRP_RST_BW_HI 8'h01
`define DPRP_RST_FILT 8'h00
`define DPRP_RST_INT_LO 8'hCB
`define DPRP_RST_INT_MID 8'h07
`define DPRP_RST_INT_TOP 8'h00
`define DPRP_RST_NUM_LO 8'h04
`define DPRP_RST_NUM_MID 8'h00
`define DPRP_RST_NUM_TOP 8'h00
`define DPRP_RST_MOD_LO 8'h05
`define DPRP_RST_MOD_MID 8'h00
`define DPRP_RST_MOD_TOP 8'h00

// ----------------------------------------------------------------------
// Writable bit masks and field positions.
// ----------------------------------------------------------------------
`define DPRP_MASK_FULL 8'hFF
`define DPRP_MASK_PRIO 8'h07
`define DPRP_MASK_FILT 8'h02
`define DPRP_MASK_INT_TOP 8'h01
`define DPRP_MASK_TOP7 8'h7F
`define DPRP_MASK_NONE 8'h00
`define DPRP_BIT_ENABLE 0
`define DPRP_BIT_PRIO_LO 1
`define DPRP_BIT_PRIO_HI 2
`define DPRP_BIT_FILTER_HPM 1
`define DPRP_BIT_INT_B16 0
`define DPRP_BIT_STAT_PERMIT 0
`define DPRP_BIT_STAT_MOD_ZERO 1
`define DPRP_BIT_STAT_NUM_OVER 2

`endif

// File: rtl/dprp_unused_placeholder_removed.v
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Intentionally empty.
// ----------------------------------------------------------------------

// File: tb/dprp_ref_profile_monitor.sv
`timescale 1ns/1ns
module dprp_ref_profile_monitor #(
    parameter ADDR_W = 16
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [ADDR_W-1:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic [1:0] reference_priority_level,
    input logic reference_lock_permit,
    input logic [15:0] loop_bw_scale,
    input logic loop_filter_high_pm,
    input logic [16:0] integer_feedback_divider_m1,
    input logic [17:0] integer_feedback_divider,
    input logic [22:0] fraction_numerator,
    input logic [22:0] fraction_modulus,
    input logic fraction_valid
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire wr_ok = psel && penable && pwrite && pstrb[0];
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error flag outside access phase");
    a_misalign_err: assert property (psel && penable &&
        paddr[1:0] != 2'b00
        |-> pslverr) else $error("misaligned access not refused");
    a_rdata_upper: assert property (prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_div_plus: assert property (integer_feedback_divider ==
        {1'b0, $past(integer_feedback_divider_m1)} + 18'h00001)
        else $error("divider is not stored value plus one");
    a_frac_valid: assert property (fraction_valid ==
        $past(fraction_modulus != 23'h0 &&
        fraction_numerator < fraction_modulus))
        else $error("fraction valid flag wrong");
    a_permit_wr: assert property (wr_ok && paddr == 16'h159C |=>
        {reference_priority_level, reference_lock_permit} ==
        $past(pwdata[2:0])) else $error("priority write not applied");
    a_bw_wr: assert property (wr_ok && paddr == 16'h15A0 |=>
        loop_bw_scale[7:0] == $past(pwdata[7:0]))
        else $error("bandwidth low byte write not applied");
    a_fields_hold: assert property (!wr_ok |=> $stable({loop_bw_scale,
        reference_priority_level, reference_lock_permit, loop_filter_high_pm,
        integer_feedback_divider_m1, fraction_numerator, fraction_modulus}))
        else $error("field changed without a write");
endmodule // dprp_ref_profile_monitor

bind dprp_ref_profile dprp_ref_profile_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_priority_level(reference_priority_level),
    .reference_lock_permit(reference_lock_permit),
    .loop_bw_scale(loop_bw_scale), .loop_filter_high_pm(loop_filter_high_pm),
    .integer_feedback_divider_m1(integer_feedback_divider_m1),
    .integer_feedback_divider(integer_feedback_divider),
    .fraction_numerator(fraction_numerator),
    .fraction_modulus(fraction_modulus), .fraction_valid(fraction_valid));

// File: tb/tb_dprp_ref_profile.sv
`timescale 1ns/1ns
module tb_dprp_ref_profile;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    wire [31:0] prdata;
    wire pready, pslverr, permit, filt, fvalid;
    wire [1:0] prio;
    wire [15:0] bw;
    wire [16:0] dm1;
    wire [17:0] div;
    wire [22:0] num, modu;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic er;
    logic [7:0] rst_t [13] = '{8'h00, 8'hF4, 8'h01, 8'h00, 8'hCB, 8'h07,
        8'h00, 8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00};
    logic [7:0] msk_t [13] = '{8'h07, 8'hFF, 8'hFF, 8'h02, 8'hFF, 8'hFF,
        8'h01, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h7F};
    dprp_ref_profile #(.ADDR_W(16)) u_dprp_ref_profile (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reference_priority_level(prio), .reference_lock_permit(permit),
        .loop_bw_scale(bw), .loop_filter_high_pm(filt),
        .integer_feedback_divider_m1(dm1), .integer_feedback_divider(div),
        .fraction_numerator(num), .fraction_modulus(modu),
        .fraction_valid(fvalid));
    initial
    begin
        forever #5 pclk = ~pclk;
    end
    // Registers sit on word indices, so the byte address is four times it.
    function automatic logic [15:0] ba(input logic [11:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Wait states are allowed; the access phase lasts until pready, for at most 50 edges.
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [7:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50)
            err_total++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, 4'h0);
        chk({er, rd}, {1'b0, 24'h000000, exp});
    endtask
    // Two edges cover the extra cycle of the derived divider and flag.
    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            close_out();
        end
    end
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 13; i++)
            rd_chk(ba(12'h567 + i), rst_t[i]);
        #1;
        chk({prio, permit, filt}, 4'h0);
        chk({bw, div}, {16'd500, 18'd1996});
        chk({num, modu, fvalid}, {23'd4, 23'd5, 1'b1});
        $display("test reset values done");
        for (int v = 0; v < 2; v++)
        begin
            for (int i = 0; i < 13; i++)
            begin
                apb(1'b1, ba(12'h567 + i), v ? 8'h00 : 8'hFF, 4'hF);
                rd_chk(ba(12'h567 + i), v ? 8'h00 : msk_t[i]);
            end
            settle();
            chk({prio, permit, filt, bw}, v ? 20'h0 : 20'hFFFFF);
            chk(div, v ? 18'h1 : 18'h20000);
            chk({num, modu, fvalid}, v ? 47'h0 : 47'h7FFFFFFFFFFE);
        end
        $display("test writable bits done");
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, ba(12'h567), {5'h00, c[1:0], c[0]}, 4'hF);
            settle();
            chk({prio, permit}, {c[1:0], c[0]});
        end
        $display("test priority codes done");
        apb(1'b1, ba(12'h56B), 8'hFF, 4'hF);
        apb(1'b1, ba(12'h56D), 8'h01, 4'hF);
        apb(1'b1, ba(12'h56E), 8'h03, 4'hF);
        apb(1'b1, ba(12'h571), 8'h07, 4'hF);
        apb(1'b1, ba(12'h569), 8'h12, 4'hF);
        settle();
        chk({dm1, div}, {17'h100FF, 18'h10100});
        chk({bw, fvalid}, {16'h1200, 1'b1});
        apb(1'b1, ba(12'h56E), 8'h07, 4'hF);
        settle();
        chk(fvalid, 1'b0);
        $display("test divider fields done");
        // Software side: bandwidth kept above 50 Hz and below a twentieth
        // of the detector rate, high margin filter picked above 2 kHz.
        apb(1'b1, ba(12'h568), 8'h00, 4'hF);
        apb(1'b1, ba(12'h569), 8'h56, 4'hF);
        apb(1'b1, ba(12'h56A), 8'h02, 4'hF);
        settle();
        chk({bw, filt}, {16'h5600, 1'b1});
        $display("test software limits done");
        apb(1'b1, ba(12'h56E) + 16'h0001, 8'h01, 4'hF);
        chk(er, 1'b1);
        apb(1'b1, ba(12'h56E), 8'h01, 4'h0);
        chk(er, 1'b0);
        apb(1'b1, ba(12'h574), 8'hFF, 4'hF);
        chk(er, 1'b1);
        apb(1'b0, ba(12'h575), 8'h00, 4'h0);
        chk(er, 1'b1);
        rd_chk(ba(12'h56E), 8'h07);
        rd_chk(ba(12'h574), 8'h05);
        $display("test refused accesses done");
        close_out();
    end
endmodule // tb_dprp_ref_profile
